/* File: verilog/plc_params.svh */
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH
`define PLC_OFS_LINK_CONFIG   12'h530
`define PLC_OFS_LINK_STATE    12'h540
`define PLC_OFS_PRBS_SEED     12'h55C
`define PLC_BIT_LEGACY        8
`define PLC_BIT_XLINK_DIS     11
`define PLC_BIT_SPEED_CTL     14
`define PLC_BIT_RETRAIN       31
`define PLC_RST_LEGACY        1'h0
`define PLC_RST_XLINK_DIS     1'h0
`define PLC_RST_SPEED_DOWN    1'h0
`define PLC_RST_SPEED_OTHER   1'h1
`define PLC_RST_SEED          16'hFFFF
`define PLC_RETRAIN_DELAY_NS  1000000
`define PLC_CLK_PERIOD_NS     25
`define PLC_RETRAIN_CYCLES    (`PLC_RETRAIN_DELAY_NS / `PLC_CLK_PERIOD_NS)
`define PLC_RESP_OKAY         2'h0
`define PLC_RESP_SLVERR       2'h2
`endif

/* File: verilog/plc_pkg.sv */
package plc_pkg;
   typedef struct packed {
      logic        legacy_compat_enable;
      logic        crosslink_disable;
      logic        initial_speed_change_ctl;
   } plc_ctrl_t;

   typedef struct packed {
      logic        prbs_load;
      logic [15:0] prbs_seed;
      logic [15:0] prbs_value;
   } plc_prbs_t;

   typedef enum logic [1:0] {
      PLC_RT_IDLE = 2'b00,
      PLC_RT_RESP = 2'b01,
      PLC_RT_WAIT = 2'b10,
      PLC_RT_FIRE = 2'b11
   } plc_rt_state_t;
endpackage

/* File: verilog/plc_link_regs.sv */
`timescale 1ns/1ps
`include "plc_params.svh"
module plc_link_regs #(
   parameter int unsigned RETRAIN_CYCLES = `PLC_RETRAIN_CYCLES
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Port mode, static from reset
   input  wire logic              port_is_downstream,
   // AXI4-Lite write
   input  wire logic [11:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // PHY controls
   output plc_pkg::plc_ctrl_t     phy_ctrl,
   output logic                   ltssm_to_detect,
   output plc_pkg::plc_prbs_t     phy_prbs
);
   import plc_pkg::*;

   logic [11:0]   aw_addr_q;
   logic          aw_have_q;
   logic [31:0]   w_data_q;
   logic [3:0]    w_strb_q;
   logic          w_have_q;
   logic          legacy_q;
   logic          xlink_dis_q;
   logic          speed_ctl_q;
   logic [1:0]    init_cnt_q;
   logic          mode_meta_q;
   logic          mode_sync_q;
   logic [15:0]   seed_q;
   logic [15:0]   lfsr_q;
   logic          lfsr_load_q;
   logic          retrain_req;
   logic [31:0]   rt_cnt_q;
   logic          detect_q;
   logic          down_q;
   plc_rt_state_t rt_state_q;
   logic          wr_go;
   logic          wr_hit_cfg;
   logic          wr_hit_state;
   logic          wr_hit_seed;
   logic [15:0]   seed_d;
   logic [31:0]   seed_wmask;
   logic          seed_chg;

   function automatic logic [31:0] plc_mask(input logic [3:0] strb);
      plc_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   function automatic logic plc_mapped(input logic [11:0] a);
      plc_mapped = (a == `PLC_OFS_LINK_CONFIG) || (a == `PLC_OFS_LINK_STATE)
                   || (a == `PLC_OFS_PRBS_SEED);
   endfunction

   // Write address and data, taken in either order
   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_hit_cfg   = wr_go && (aw_addr_q == `PLC_OFS_LINK_CONFIG);
   assign wr_hit_state = wr_go && (aw_addr_q == `PLC_OFS_LINK_STATE);
   assign wr_hit_seed  = wr_go && (aw_addr_q == `PLC_OFS_PRBS_SEED);
   assign retrain_req  = wr_hit_state && w_strb_q[3]
                         && w_data_q[`PLC_BIT_RETRAIN];
   assign seed_wmask = plc_mask(w_strb_q);
   assign seed_d = (seed_q & ~seed_wmask[15:0]) |
                   (w_data_q[15:0] & seed_wmask[15:0]);
   assign seed_chg = wr_hit_seed && (seed_d != seed_q);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_q     <= 1'b0;
         aw_addr_q     <= 12'h000;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= 1'b0;
         if (s_axi_awvalid && !aw_have_q && !s_axi_awready) begin
            aw_have_q     <= 1'b1;
            aw_addr_q     <= {s_axi_awaddr[11:2], 2'b00};
            s_axi_awready <= 1'b1;
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         w_have_q     <= 1'b0;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= 1'b0;
         if (s_axi_wvalid && !w_have_q && !s_axi_wready) begin
            w_have_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b1;
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PLC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= plc_mapped(aw_addr_q) ? `PLC_RESP_OKAY
                                               : `PLC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Two-stage synchroniser for the mode strap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_meta_q <= 1'b0;
         mode_sync_q <= 1'b0;
      end else begin
         mode_meta_q <= port_is_downstream;
         mode_sync_q <= mode_meta_q;
      end
   end

   // Settling count, synchroniser output valid from two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         init_cnt_q <= 2'h0;
      end else if (init_cnt_q != 2'h3) begin
         init_cnt_q <= init_cnt_q + 2'h1;
      end
   end

   // Port mode taken once the synchroniser has settled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         down_q <= 1'b0;
      end else if (init_cnt_q != 2'h3) begin
         down_q <= mode_sync_q;
      end
   end

   // Control bits sit in byte one only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         legacy_q    <= `PLC_RST_LEGACY;
         xlink_dis_q <= `PLC_RST_XLINK_DIS;
         speed_ctl_q <= `PLC_RST_SPEED_OTHER;
      end else if (init_cnt_q != 2'h3) begin
         speed_ctl_q <= mode_sync_q ? `PLC_RST_SPEED_DOWN
                                    : `PLC_RST_SPEED_OTHER;
      end else if (wr_hit_cfg) begin
         if (w_strb_q[1]) begin
            legacy_q    <= w_data_q[`PLC_BIT_LEGACY];
            xlink_dis_q <= w_data_q[`PLC_BIT_XLINK_DIS];
            speed_ctl_q <= w_data_q[`PLC_BIT_SPEED_CTL];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seed_q      <= `PLC_RST_SEED;
         lfsr_load_q <= 1'b0;
      end else begin
         lfsr_load_q <= 1'b0;
         // Same value written leaves the counter running
         if (seed_chg) begin
            seed_q      <= seed_d;
            lfsr_load_q <= 1'b1;
         end
      end
   end

   // PRBS counter, x^16+x^15+x^13+x^4+1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_q <= `PLC_RST_SEED;
      end else if (seed_chg) begin
         lfsr_q <= seed_d;
      end else begin
         lfsr_q <= {lfsr_q[14:0],
                    lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
      end
   end

   // Retrain sequencer: response first, then Detect
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rt_state_q <= PLC_RT_IDLE;
         rt_cnt_q   <= 32'h0000_0000;
         detect_q   <= 1'b0;
      end else begin
         detect_q <= 1'b0;
         case (rt_state_q)
            PLC_RT_IDLE: begin
               if (retrain_req) begin
                  rt_state_q <= PLC_RT_RESP;
               end
            end
            PLC_RT_RESP: begin
               if (s_axi_bvalid && s_axi_bready) begin
                  rt_cnt_q   <= 32'h0000_0000;
                  rt_state_q <= down_q ? PLC_RT_FIRE : PLC_RT_WAIT;
               end
            end
            PLC_RT_WAIT: begin
               rt_cnt_q <= rt_cnt_q + 32'h0000_0001;
               if (rt_cnt_q >= RETRAIN_CYCLES - 1) begin
                  rt_state_q <= PLC_RT_FIRE;
               end
            end
            PLC_RT_FIRE: begin
               detect_q   <= 1'b1;
               rt_state_q <= PLC_RT_IDLE;
            end
            default: rt_state_q <= PLC_RT_IDLE;
         endcase
      end
   end

   // Read channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `PLC_RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `PLC_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            case ({s_axi_araddr[11:2], 2'b00})
               `PLC_OFS_LINK_CONFIG: begin
                  s_axi_rdata[`PLC_BIT_LEGACY]    <= legacy_q;
                  s_axi_rdata[`PLC_BIT_XLINK_DIS] <= xlink_dis_q;
                  s_axi_rdata[`PLC_BIT_SPEED_CTL] <= speed_ctl_q;
               end
               `PLC_OFS_LINK_STATE: s_axi_rdata <= 32'h0000_0000;
               `PLC_OFS_PRBS_SEED: s_axi_rdata[15:0] <= seed_q;
               default: s_axi_rresp <= `PLC_RESP_SLVERR;
            endcase
         end
      end
   end

   // Registered outputs to PHY
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phy_ctrl        <= '{`PLC_RST_LEGACY, `PLC_RST_XLINK_DIS,
                              `PLC_RST_SPEED_OTHER};
         ltssm_to_detect <= 1'b0;
         phy_prbs        <= '{1'b0, `PLC_RST_SEED, `PLC_RST_SEED};
      end else begin
         phy_ctrl.legacy_compat_enable     <= legacy_q;
         phy_ctrl.crosslink_disable        <= xlink_dis_q;
         phy_ctrl.initial_speed_change_ctl <= speed_ctl_q;
         ltssm_to_detect                   <= detect_q;
         phy_prbs.prbs_load                <= lfsr_load_q;
         phy_prbs.prbs_seed                <= seed_q;
         phy_prbs.prbs_value               <= lfsr_q;
      end
   end
endmodule // plc_link_regs

/* File: bench/plc_link_regs_asserts.sv */
`timescale 1ns/1ps
module plc_link_regs_chk #(
   parameter int unsigned RETRAIN_CYCLES = 20
) (
   // Clock, reset, mode
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               port_is_downstream,
   // Bus
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic               s_axi_rvalid,
   // PHY side
   input wire plc_pkg::plc_ctrl_t phy_ctrl,
   input wire logic               ltssm_to_detect,
   input wire plc_pkg::plc_prbs_t phy_prbs
);
   import plc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
   a_rd_hi: assert property (p_rd_hi)
      else $error("read data upper half not zero");
   property p_no_early; $rose(s_axi_bvalid) |-> !ltssm_to_detect [*3]; endproperty
   a_no_early: assert property (p_no_early)
      else $error("retrain fired before completion");
   property p_pulse; ltssm_to_detect |=> !ltssm_to_detect; endproperty
   a_pulse: assert property (p_pulse)
      else $error("detect request longer than one cycle");
   property p_load_val;
      phy_prbs.prbs_load |-> phy_prbs.prbs_value == phy_prbs.prbs_seed;
   endproperty
   a_load_val: assert property (p_load_val)
      else $error("counter not reloaded with seed");
   property p_seed_load; !$stable(phy_prbs.prbs_seed) |-> phy_prbs.prbs_load;
   endproperty
   a_seed_load: assert property (p_seed_load)
      else $error("seed changed without reload");
   property p_spd_rst;
      $rose(rst_n) |-> ##4 phy_ctrl.initial_speed_change_ctl == !port_is_downstream;
   endproperty
   a_spd_rst: assert property (p_spd_rst)
      else $error("speed control reset value wrong");
   property p_rd_lat; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
endmodule // plc_link_regs_chk
bind plc_link_regs plc_link_regs_chk #(.RETRAIN_CYCLES(RETRAIN_CYCLES)) u_chk (.*);

/* File: bench/plc_phy_model.sv */
`timescale 1ns/1ps
module plc_phy_model (
   // Clock and reset
   input wire logic               clk,
   input wire logic               rst_n,
   // From the block
   input wire logic               det,
   input wire plc_pkg::plc_prbs_t prbs,
   // Observed state
   output logic [7:0]             det_cnt_q,
   output logic [15:0]            seed_q
);
   import plc_pkg::*;
   // Partner drops to Detect on each request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) det_cnt_q <= 8'h00;
      else if (det) det_cnt_q <= det_cnt_q + 8'h01;
   end
   // Crosslink sequence restarts from the loaded seed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) seed_q <= 16'hFFFF;
      else if (prbs.prbs_load) seed_q <= prbs.prbs_value;
   end
endmodule // plc_phy_model

/* File: bench/phy_link_control_regs_test.sv */
`timescale 1ns/1ps
`include "plc_params.svh"
module phy_link_control_regs_test;
   import plc_pkg::*;
   localparam int RT = 20;
   logic        clk, rst_n, down, awv, wv, bry, arv, rry;
   logic        awr, wrdy, bv, arr, rv, det;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdat;
   logic [3:0]  ws;
   logic [1:0]  br, rr;
   plc_ctrl_t   ctrl;
   plc_prbs_t   prbs;
   logic [7:0]  det_cnt;
   logic [15:0] seed;
   int          failures, checked;
   plc_link_regs #(.RETRAIN_CYCLES(RT)) dut (.clk(clk), .rst_n(rst_n),
      .port_is_downstream(down), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .phy_ctrl(ctrl), .ltssm_to_detect(det), .phy_prbs(prbs));
   plc_phy_model u_phy (.clk(clk), .rst_n(rst_n), .det(det), .prbs(prbs),
      .det_cnt_q(det_cnt), .seed_q(seed));
   task automatic conclude;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] e);
      int n;
      n = 0;
      @(posedge clk);
      awa <= a; wd <= d; ws <= s; awv <= 1'b1; wv <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
         n++;
      end while (!bv && n < 50);
      // Late bready exercises response hold
      bry <= 1'b1;
      @(posedge clk);
      bry <= 1'b0;
      chk(br, e);
      if (n >= 50) failures++;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      ara <= a; arv <= 1'b1; rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         n++;
      end while (!rv && n < 50);
      rry <= 1'b0;
      chk(rr, er);
      if (er == `PLC_RESP_OKAY) chk(rdat, e);
      if (n >= 50) failures++;
   endtask
   task automatic rtr(input int lo, input int hi);
      int k;
      k = 0;
      wr(`PLC_OFS_LINK_STATE, 32'h8000_0000, 4'hF, `PLC_RESP_OKAY);
      while (!det && k < hi + 5) begin
         @(posedge clk);
         k++;
      end
      @(posedge clk);
      chk(32'(k >= lo && k <= hi), 32'h1);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #125000;
      failures++;
      conclude;
   end
   initial begin
      rst_n = 0; down = 1; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0;
      awa = 0; ara = 0; wd = 0; ws = 0; failures = 0; checked = 0;
      for (int m = 1; m >= 0; m--) begin
         down <= 1'(m);
         rst_n <= 1'b0;
         repeat (6) @(posedge clk);
         rst_n <= 1'b1;
         repeat (3) @(posedge clk);
         rd(`PLC_OFS_LINK_CONFIG, m ? 32'h0 : 32'h4000, 2'h0);
         chk(ctrl, m ? 3'h0 : 3'h1);
         rd(`PLC_OFS_LINK_STATE, 32'h0, 2'h0);
         rd(`PLC_OFS_PRBS_SEED, 32'hFFFF, 2'h0);
         wr(`PLC_OFS_LINK_CONFIG, 32'hFFFF_FFFF, 4'hF, 2'h0);
         rd(`PLC_OFS_LINK_CONFIG, 32'h4900, 2'h0);
         chk(ctrl, 3'h7);
         wr(`PLC_OFS_LINK_CONFIG, 32'h0, 4'hD, 2'h0);
         rd(`PLC_OFS_LINK_CONFIG, 32'h4900, 2'h0);
         wr(`PLC_OFS_LINK_CONFIG, 32'h0, 4'hF, 2'h0);
         chk(ctrl, 3'h0);
         wr(`PLC_OFS_PRBS_SEED, 32'hFFFF_A5C3, 4'hF, 2'h0);
         rd(`PLC_OFS_PRBS_SEED, 32'hA5C3, 2'h0);
         chk(seed, 16'hA5C3);
         rtr(m ? 1 : RT, m ? 6 : RT + 6);
         chk(det_cnt, 8'h01);
         rd(`PLC_OFS_LINK_STATE, 32'h0, 2'h0);
         wr(12'h600, 32'h1, 4'hF, `PLC_RESP_SLVERR);
         rd(12'h600, 32'h0, `PLC_RESP_SLVERR);
      end
      conclude;
   end
endmodule // phy_link_control_regs_test
